/* hdl/swbs_sequencer.sv */
// sequencer top: waveforms, battery test, counters and register port
// assumes synchronous measurement samples and one alarm level from the stage
`timescale 1ns/10ps
module swbs_sequencer
  import swbs_pkg::*;
#(
  parameter int SW = 16
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [SW-1:0] i_meas_volt,
  input wire logic [SW-1:0] i_meas_curr,
  input wire logic [SW-1:0] i_meas_power,
  input wire logic i_alarm,
  output logic [SW-1:0] o_volt_set,
  output logic [SW-1:0] o_curr_set,
  output logic [SW-1:0] o_power_set,
  output logic [SW-1:0] o_res_set,
  output logic o_res_enable,
  output logic o_input_on,
  output logic o_running,
  output logic [1:0] o_reg_mode,
  output logic o_limit_signal
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [4:0] func_q;
  logic [SW-1:0] lvl_a_q, lvl_b_q, stat_v_q, stat_i_q, stat_p_q, stat_r_q;
  logic [31:0] ivl_q [4];
  logic [SW-1:0] bthr_q [2];
  logic [31:0] btlim_q [2];
  logic [31:0] bcap_q [2];
  logic [3:0] bact_q [2];
  logic running_q, input_on_q, hold_q, tick_q;
  logic [6:0] tick_cnt_q;
  logic [1:0] seg_q;
  logic [31:0] ivl_cnt_q;
  logic [SW-1:0] sv_q;
  logic [31:0] ah_q, wh_q, ms_total_q;
  logic [6:0] msub_q;
  logic [9:0] ms_q;
  logic [5:0] sec_q, min_q;
  logic [7:0] hr_q;
  swbs_regmode_t regmode_q;
  logic sig_t, stop_t, sig_c, stop_c;

  swbs_func_t fn;
  logic wr_ctrl, start, stop, off, exitc, kill, is_bat, bm, bat_run, bat_stop;
  logic start_ok, seg_end, wave_done, on_wave;
  logic [1:0] last_seg, nxt_seg;
  logic [31:0] cur_ivl;
  logic [SW-1:0] top, base, hi, lo;

  assign fn = swbs_func_t'(func_q[2:0]);
  assign wr_ctrl = i_wr && (i_addr == A_CTRL);
  assign start = wr_ctrl && i_wdata[CB_START];
  assign stop = wr_ctrl && i_wdata[CB_STOP];
  assign off = wr_ctrl && i_wdata[CB_OFF];
  assign exitc = wr_ctrl && i_wdata[CB_EXIT];
  assign kill = exitc || off || i_alarm;
  assign is_bat = (fn == FN_BAT_STATIC) || (fn == FN_BAT_DYN);
  assign bm = (fn == FN_BAT_DYN);
  assign bat_run = running_q && is_bat;
  assign bat_stop = bat_run && ((i_meas_volt < bthr_q[bm]) || stop_t || stop_c);
  assign start_ok = start && !running_q && !kill;
  assign top = SW'(lvl_a_q + lvl_b_q);
  assign base = lvl_b_q;
  assign hi = (lvl_a_q > lvl_b_q) ? lvl_a_q : lvl_b_q;
  assign lo = (lvl_a_q > lvl_b_q) ? lvl_b_q : lvl_a_q;
  assign last_seg = (fn == FN_TRAP) ? 2'h3 : ((fn == FN_RAMP) ? 2'h0 : 2'h1);
  assign nxt_seg = (seg_q == last_seg) ? 2'h0 : seg_q + 2'h1;
  assign cur_ivl = ivl_q[seg_q];
  // zero interval still lasts one tick
  assign seg_end = tick_q && ({1'b0, ivl_cnt_q} + 33'h1 >= {1'b0, cur_ivl});
  assign wave_done = running_q && seg_end && (fn == FN_RAMP);
  assign on_wave = (running_q || hold_q) && !is_bat;

  function automatic logic [SW-1:0] entry(input logic [1:0] s);
    case (fn)
      FN_RECT: entry = (s == 2'h0) ? top : base;
      FN_TRAP: entry = (s == 2'h1 || s == 2'h2) ? top : base;
      FN_RAMP: entry = lvl_a_q;
      FN_BAT_DYN: entry = (s == 2'h0) ? hi : lo;
      default: entry = stat_i_q;
    endcase
  endfunction

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      func_q <= 5'h00;
      lvl_a_q <= '0;
      lvl_b_q <= '0;
      stat_v_q <= '0;
      stat_i_q <= '0;
      stat_p_q <= '0;
      stat_r_q <= '0;
      for (int k = 0; k < 4; k++) begin
        ivl_q[k] <= RST_WORD;
      end
      for (int k = 0; k < 2; k++) begin
        bthr_q[k] <= '0;
        btlim_q[k] <= RST_WORD;
        bcap_q[k] <= RST_WORD;
        bact_q[k] <= 4'h0;
      end
    end else if (i_wr) begin
      case (i_addr)
        A_FUNC: func_q <= i_wdata[4:0];
        A_LEVEL_A: lvl_a_q <= i_wdata[SW-1:0];
        A_LEVEL_B: lvl_b_q <= i_wdata[SW-1:0];
        A_STAT_VOLT: stat_v_q <= i_wdata[SW-1:0];
        A_STAT_CURR: stat_i_q <= i_wdata[SW-1:0];
        A_STAT_POWER: stat_p_q <= i_wdata[SW-1:0];
        A_STAT_RES: stat_r_q <= i_wdata[SW-1:0];
        default: begin
          if (i_addr[4:2] == 3'h1) begin
            ivl_q[i_addr[1:0]] <= i_wdata;
          end else if (i_addr[4:3] == 2'h2) begin
            case (i_addr[1:0])
              BF_THR: bthr_q[i_addr[2]] <= i_wdata[SW-1:0];
              BF_TLIM: btlim_q[i_addr[2]] <= i_wdata;
              BF_CAP: bcap_q[i_addr[2]] <= i_wdata;
              default: bact_q[i_addr[2]] <= i_wdata[3:0];
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // run control
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      running_q <= 1'b0;
      input_on_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (kill) begin
      running_q <= 1'b0;
      input_on_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (bat_stop) begin
      running_q <= 1'b0;
      input_on_q <= 1'b0;
    end else if (stop) begin
      running_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (start_ok) begin
      running_q <= 1'b1;
      input_on_q <= 1'b1;
      hold_q <= 1'b0;
    end else if (wave_done) begin
      running_q <= 1'b0;
      hold_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      tick_cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end else if (start_ok) begin
      // restart the timebase so the first interval is a full one
      tick_cnt_q <= 7'h01;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 7'(TICK_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == 7'(TICK_CYC - 1)) ? 7'h00 : tick_cnt_q + 7'h01;
    end
  end

  // ----------------------------------------
  // waveform engine
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      seg_q <= 2'h0;
      ivl_cnt_q <= RST_WORD;
      sv_q <= '0;
    end else if (start_ok) begin
      seg_q <= 2'h0;
      ivl_cnt_q <= RST_WORD;
      sv_q <= entry(2'h0);
    end else if (running_q && tick_q && fn != FN_BAT_STATIC) begin
      if (seg_end) begin
        ivl_cnt_q <= RST_WORD;
        seg_q <= nxt_seg;
        sv_q <= (fn == FN_RAMP) ? lvl_b_q : entry(nxt_seg);
      end else begin
        ivl_cnt_q <= ivl_cnt_q + 32'h1;
        if (fn == FN_TRAP && seg_q == 2'h0 && sv_q < top) begin
          sv_q <= sv_q + SW'(1);
        end else if (fn == FN_TRAP && seg_q == 2'h2 && sv_q > base) begin
          sv_q <= sv_q - SW'(1);
        end else if (fn == FN_RAMP && sv_q < lvl_b_q) begin
          sv_q <= sv_q + SW'(1);
        end else if (fn == FN_RAMP && sv_q > lvl_b_q) begin
          sv_q <= sv_q - SW'(1);
        end
      end
    end
  end

  // ----------------------------------------
  // battery counters
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rstn || exitc) begin
      ah_q <= RST_WORD;
      wh_q <= RST_WORD;
      ms_total_q <= RST_WORD;
      msub_q <= 7'h00;
      ms_q <= 10'h000;
      sec_q <= 6'h00;
      min_q <= 6'h00;
      hr_q <= 8'h00;
    end else if (bat_run && tick_q) begin
      ah_q <= ah_q + 32'(i_meas_curr);
      wh_q <= wh_q + 32'(i_meas_power);
      msub_q <= (msub_q == 7'(MS_TICKS - 1)) ? 7'h00 : msub_q + 7'h01;
      if (msub_q == 7'(MS_TICKS - 1)) begin
        ms_total_q <= ms_total_q + 32'h1;
        ms_q <= (ms_q == 10'(MS_PER_S - 1)) ? 10'h000 : ms_q + 10'h001;
        if (ms_q == 10'(MS_PER_S - 1)) begin
          sec_q <= (sec_q == 6'(S_PER_MIN - 1)) ? 6'h00 : sec_q + 6'h01;
          if (sec_q == 6'(S_PER_MIN - 1)) begin
            min_q <= (min_q == 6'(MIN_PER_H - 1)) ? 6'h00 : min_q + 6'h01;
            if (min_q == 6'(MIN_PER_H - 1)) begin
              hr_q <= hr_q + 8'h01;
            end
          end
        end
      end
    end
  end

  swbs_limit u_time_limit (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_run(bat_run),
    .i_clear(exitc),
    .i_value(ms_total_q),
    .i_limit(btlim_q[bm]),
    .i_action(bact_q[bm][1:0]),
    .o_flag(sig_t),
    .o_stop(stop_t)
  );

  swbs_limit u_cap_limit (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_run(bat_run),
    .i_clear(exitc),
    .i_value(ah_q),
    .i_limit(bcap_q[bm]),
    .i_action(bact_q[bm][3:2]),
    .o_flag(sig_c),
    .o_stop(stop_c)
  );

  // ----------------------------------------
  // set value outputs
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_volt_set <= '0;
      o_curr_set <= '0;
      o_power_set <= '0;
      o_res_set <= '0;
      o_res_enable <= 1'b0;
    end else begin
      o_power_set <= stat_p_q;
      o_res_set <= stat_r_q;
      // resistance limit only in static test
      o_res_enable <= func_q[FB_RES_EN] && (fn == FN_BAT_STATIC);
      o_volt_set <= (on_wave && func_q[FB_TARGET_VOLT]) ? sv_q : stat_v_q;
      if (on_wave && !func_q[FB_TARGET_VOLT]) begin
        o_curr_set <= sv_q;
      end else if (running_q && fn == FN_BAT_DYN) begin
        o_curr_set <= sv_q;
      end else begin
        o_curr_set <= stat_i_q;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      regmode_q <= RM_CONSTANT_CURRENT_REGULATION;
    end else if (i_meas_curr >= o_curr_set) begin
      regmode_q <= RM_CONSTANT_CURRENT_REGULATION;
    end else if (i_meas_power >= o_power_set) begin
      regmode_q <= RM_CONSTANT_POWER_REGULATION;
    end else if (o_res_enable) begin
      regmode_q <= RM_CONSTANT_RESISTANCE_REGULATION;
    end else begin
      regmode_q <= RM_CONSTANT_CURRENT_REGULATION;
    end
  end

  assign o_input_on = input_on_q;
  assign o_running = running_q;
  assign o_reg_mode = regmode_q;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_limit_signal <= 1'b0;
      o_rdata <= RST_WORD;
    end else begin
      o_limit_signal <= sig_t || sig_c;
      if (i_rd) begin
        case (i_addr)
          A_CTRL: o_rdata <= {26'h0, regmode_q, o_limit_signal, hold_q, input_on_q, running_q};
          A_FUNC: o_rdata <= {27'h0, func_q};
          A_LEVEL_A: o_rdata <= 32'(lvl_a_q);
          A_LEVEL_B: o_rdata <= 32'(lvl_b_q);
          A_STAT_VOLT: o_rdata <= 32'(stat_v_q);
          A_STAT_CURR: o_rdata <= 32'(stat_i_q);
          A_STAT_POWER: o_rdata <= 32'(stat_p_q);
          A_STAT_RES: o_rdata <= 32'(stat_r_q);
          A_AH: o_rdata <= ah_q;
          A_WH: o_rdata <= wh_q;
          A_TIME: o_rdata <= {2'h0, hr_q, min_q, sec_q, ms_q};
          A_SETVAL: o_rdata <= 32'(sv_q);
          default: begin
            if (i_addr[4:2] == 3'h1) begin
              o_rdata <= ivl_q[i_addr[1:0]];
            end else if (i_addr[4:3] != 2'h2) begin
              o_rdata <= RST_WORD;
            end else begin
              case (i_addr[1:0])
                BF_THR: o_rdata <= 32'(bthr_q[i_addr[2]]);
                BF_TLIM: o_rdata <= btlim_q[i_addr[2]];
                BF_CAP: o_rdata <= bcap_q[i_addr[2]];
                default: o_rdata <= {28'h0, bact_q[i_addr[2]]};
              endcase
            end
          end
        endcase
      end else begin
        o_rdata <= RST_WORD;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  sequence s_halted;
    !running_q && !input_on_q;
  endsequence
  sequence s_ramp_held;
    hold_q && !running_q;
  endsequence

  a_alarm_halts: assert property (i_alarm |=> s_halted)
    else $error("alarm did not stop the run");
  a_enter_keeps_on: assert property (stop && !kill && input_on_q && !bat_stop
    |=> input_on_q && !running_q)
    else $error("enter stop lost the input");
  a_idle_static: assert property (!running_q && !hold_q ##1 !running_q && !hold_q
    |-> o_curr_set == $past(stat_i_q) && o_volt_set == $past(stat_v_q))
    else $error("static set values not applied while idle");
  a_rect_pulse: assert property (running_q && fn == FN_RECT && seg_q == 2'h0 && !start_ok
    |-> sv_q == top)
    else $error("rectangle pulse level wrong");
  a_seg_advance: assert property (running_q && seg_end && !kill && !bat_stop && !stop
    && fn != FN_RAMP && fn != FN_BAT_STATIC |=> seg_q == $past(nxt_seg))
    else $error("segment did not advance after its interval");
  a_thr_stop: assert property (bat_run && i_meas_volt < bthr_q[bm] |=> s_halted)
    else $error("threshold did not stop the test");
  a_ramp_once: assert property (wave_done && !kill && !bat_stop && !stop
    |=> s_ramp_held ##1 (s_ramp_held or kill or start_ok or stop or $past(kill || stop || start_ok)))
    else $error("ramp restarted or dropped end level");
  a_dyn_upper: assert property (running_q && fn == FN_BAT_DYN && seg_q == 2'h0
    |-> sv_q >= lvl_a_q && sv_q >= lvl_b_q)
    else $error("dynamic upper level is not the larger current");
  a_acc_idle: assert property (!bat_run && !exitc |=> $stable(ah_q) && $stable(wh_q))
    else $error("counter moved while not running");
  a_volt_only: assert property (on_wave && func_q[FB_TARGET_VOLT]
    |=> o_curr_set == $past(stat_i_q) && o_volt_set == $past(sv_q))
    else $error("wrong quantity modulated");
endmodule // swbs_sequencer

/* hdl/swbs_pkg.sv */
// package: constants and types of the setpoint waveform and battery sequencer
// assumes a 10 MHz system clock and a plain word-indexed register port
// Functional notes
// - rectangle drives offset plus amplitude for pulse, then offset for pause, repeating.
// - rectangle period is pulse interval plus pause interval.
// - each waveform interval programmable from ten microseconds to 36000 seconds.
// - trapezoid cycles rise, top hold, fall, base hold, then repeats.
// - rise and fall durations are programmed independently.
// - ramp moves linearly from start to end over up to 36000 seconds.
// - ramp runs once and then holds the end level.
// - static battery test uses constant current with power and optional resistance limits.
// - regulation mode follows the first limiting set value and is reported.
// - dynamic battery test pulses two currents, larger one taken as upper.
// - upper current for pulse interval, lower for pause interval, each programmable.
// - battery test stops when input voltage falls below the discharge threshold.
// - elapsed time compared against a maximum, triggering the time limit action.
// - consumed charge compared against a maximum, triggering the capacity limit action.
// - per limit action: none continues, signal flags and continues, stop ends.
// - threshold, limits and actions stored separately for static and dynamic mode.
// - counters for ampere-hours, watt-hours and elapsed time in h, min, s, ms.
// - an input-off alarm stops the battery test at once.
// - stopped test resumes with counters kept; counters clear on leaving context.
// - waveform modulates one of voltage or current; other set values stay constant.
// - enter stop halts waveform but keeps input on with static values.
// - static set values apply before the waveform starts and after it ends; a finished ramp keeps its end level instead.
package swbs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS = 10_000;
  localparam int unsigned TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned MS_TICKS = MS_NS / TICK_NS;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned S_PER_MIN = 60;
  localparam int unsigned MIN_PER_H = 60;
  // register indices
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_FUNC = 5'h01;
  localparam logic [4:0] A_LEVEL_A = 5'h02;
  localparam logic [4:0] A_LEVEL_B = 5'h03;
  localparam logic [4:0] A_IVL_BASE = 5'h04;
  localparam logic [4:0] A_STAT_VOLT = 5'h08;
  localparam logic [4:0] A_STAT_CURR = 5'h09;
  localparam logic [4:0] A_STAT_POWER = 5'h0a;
  localparam logic [4:0] A_STAT_RES = 5'h0b;
  localparam logic [4:0] A_AH = 5'h0c;
  localparam logic [4:0] A_WH = 5'h0d;
  localparam logic [4:0] A_TIME = 5'h0e;
  localparam logic [4:0] A_SETVAL = 5'h0f;
  localparam logic [4:0] A_BAT_BASE = 5'h10;
  localparam logic [1:0] BF_THR = 2'h0;
  localparam logic [1:0] BF_TLIM = 2'h1;
  localparam logic [1:0] BF_CAP = 2'h2;
  localparam logic [1:0] BF_ACT = 2'h3;
  // control write bits and func fields
  localparam int unsigned CB_START = 0;
  localparam int unsigned CB_STOP = 1;
  localparam int unsigned CB_OFF = 2;
  localparam int unsigned CB_EXIT = 3;
  localparam int unsigned FB_TARGET_VOLT = 3;
  localparam int unsigned FB_RES_EN = 4;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [2:0] {FN_RECT, FN_TRAP, FN_RAMP, FN_BAT_STATIC, FN_BAT_DYN} swbs_func_t;
  typedef enum logic [1:0] {ACT_NONE, ACT_SIGNAL, ACT_LIMIT_STOP} swbs_act_t;
  typedef enum logic [1:0] {
    RM_CONSTANT_CURRENT_REGULATION,
    RM_CONSTANT_POWER_REGULATION,
    RM_CONSTANT_RESISTANCE_REGULATION
  } swbs_regmode_t;
endpackage

/* hdl/swbs_limit.sv */
// limit watcher: compares a running count against a maximum
// assumes value and limit in the same unit; a limit of zero is off
`timescale 1ns/10ps
module swbs_limit
  import swbs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic [31:0] i_value,
  input wire logic [31:0] i_limit,
  input wire logic [1:0] i_action,
  output logic o_flag,
  output logic o_stop
);
  logic hit_q;
  logic hit;
  assign hit = i_run && (i_limit != RST_WORD) && (i_value >= i_limit);

  // sticky reach, set wins over clear
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      hit_q <= 1'b0;
    end else if (hit) begin
      hit_q <= 1'b1;
    end else if (i_clear) begin
      hit_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_flag <= 1'b0;
      o_stop <= 1'b0;
    end else begin
      o_stop <= hit && !hit_q && (i_action == ACT_LIMIT_STOP);
      if (hit && !hit_q && (i_action != ACT_NONE)) begin
        o_flag <= 1'b1;
      end else if (i_clear) begin
        o_flag <= 1'b0;
      end
    end
  end
endmodule // swbs_limit

/* tb/swbs_stage_model.sv */
// power stage model: turns set values into measured samples
// assumes the bench supplies the battery voltage level
`timescale 1ns/10ps
module swbs_stage_model #(
  parameter int SW = 16
) (
  input wire logic i_clock,
  input wire logic [SW-1:0] i_curr_set,
  input wire logic i_input_on,
  input wire logic [SW-1:0] i_batt_volt,
  output logic [SW-1:0] o_meas_volt,
  output logic [SW-1:0] o_meas_curr,
  output logic [SW-1:0] o_meas_power
);
  logic [2*SW-1:0] prod;
  assign prod = i_batt_volt * o_meas_curr;
  // draws current only while the input is on
  always_ff @(posedge i_clock) begin
    o_meas_volt <= i_batt_volt;
    o_meas_curr <= i_input_on ? i_curr_set : '0;
    o_meas_power <= prod[SW+7:8];
  end
endmodule // swbs_stage_model

/* tb/swbs_sequencer_tb.sv */
// bench for the sequencer: waveforms, battery test, limits, counters
// assumes the stage model on the set and measurement ports
`timescale 1ns/10ps
module swbs_sequencer_tb
  import swbs_pkg::*;
;
  logic i_clock = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_alarm = 0;
  logic [4:0] i_addr = '0;
  logic [31:0] i_wdata = '0, o_rdata, rd, a1;
  logic [15:0] mv, mc, mp, o_volt_set, o_curr_set, o_power_set, o_res_set, batt = 16'h0200;
  logic o_res_enable, o_input_on, o_running, o_limit_signal;
  logic [1:0] o_reg_mode;
  int fail_count = 0, n_checks = 0;
  // rectangle rows: cycles to wait, expected current set value
  int unsigned rw [5] = '{50, 100, 100, 100, 100};
  logic [15:0] rx [5] = '{16'h0030, 16'h0020, 16'h0020, 16'h0030, 16'h0020};
  swbs_sequencer #(.SW(16)) DUT (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_meas_volt(mv),
    .i_meas_curr(mc), .i_meas_power(mp), .i_alarm(i_alarm), .o_volt_set(o_volt_set),
    .o_curr_set(o_curr_set), .o_power_set(o_power_set), .o_res_set(o_res_set),
    .o_res_enable(o_res_enable), .o_input_on(o_input_on), .o_running(o_running),
    .o_reg_mode(o_reg_mode), .o_limit_signal(o_limit_signal));
  swbs_stage_model #(.SW(16)) stage (.i_clock(i_clock), .i_curr_set(o_curr_set),
    .i_input_on(o_input_on), .i_batt_volt(batt), .o_meas_volt(mv), .o_meas_curr(mc),
    .o_meas_power(mp));
  initial begin
    forever #50 i_clock = ~i_clock;
  end
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [4:0] a);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 rd = o_rdata;
  endtask
  task automatic cyc(input int unsigned n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #4_000_000;
    fail_count++;
    report_and_stop();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    cyc(1);
    check(o_running, 1'b0, "run after reset");
    check(o_curr_set, 16'h0, "current after reset");
    rdr(5'h1f);
    check(rd, 32'h0, "unmapped read");
    // rectangle on current: amplitude 0x10, offset 0x20, one and two ticks
    wr(A_FUNC, 32'h0);
    wr(A_LEVEL_A, 32'h10);
    wr(A_LEVEL_B, 32'h20);
    wr(A_IVL_BASE, 32'h1);
    wr(A_IVL_BASE + 5'h1, 32'h2);
    wr(A_STAT_CURR, 32'h07);
    wr(A_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) begin
      cyc(rw[i]);
      check(o_curr_set, rx[i], "rectangle level");
    end
    wr(A_CTRL, 32'h2);
    cyc(3);
    check({o_running, o_input_on}, 2'b01, "enter stop");
    check(o_curr_set, 16'h07, "static after stop");
    // trapezoid on current: rise 4 ticks, top 2, fall 2, base 2
    wr(A_FUNC, 32'h1);
    wr(A_LEVEL_A, 32'h4);
    wr(A_IVL_BASE, 32'h4);
    wr(A_IVL_BASE + 5'h2, 32'h2);
    wr(A_IVL_BASE + 5'h3, 32'h2);
    wr(A_CTRL, 32'h1);
    cyc(250);
    check(o_curr_set, 16'h22, "trapezoid rise");
    cyc(300);
    check(o_curr_set, 16'h24, "trapezoid top");
    cyc(200);
    check(o_curr_set, 16'h23, "trapezoid fall");
    cyc(200);
    check(o_curr_set, 16'h20, "trapezoid base");
    cyc(200);
    check(o_curr_set, 16'h21, "trapezoid repeats");
    wr(A_CTRL, 32'h2);
    // single ramp on voltage, current stays static
    wr(A_FUNC, 32'h0a);
    wr(A_LEVEL_A, 32'h10);
    wr(A_LEVEL_B, 32'h14);
    wr(A_IVL_BASE, 32'h4);
    wr(A_STAT_VOLT, 32'h10);
    wr(A_STAT_CURR, 32'h55);
    wr(A_CTRL, 32'h1);
    cyc(250);
    check(o_volt_set > 16'h10 && o_volt_set < 16'h14, 1'b1, "ramp midway");
    check(o_curr_set, 16'h55, "unmodulated current");
    cyc(400);
    check({o_volt_set, o_running}, {16'h14, 1'b0}, "ramp end");
    cyc(500);
    check(o_volt_set, 16'h14, "ramp holds");
    wr(A_CTRL, 32'h8);
    // static battery test, time limit 1 ms with signal action
    wr(A_FUNC, 32'h13);
    wr(A_STAT_CURR, 32'h40);
    wr(A_STAT_POWER, 32'hffff);
    wr(A_BAT_BASE, 32'h100);
    wr(A_BAT_BASE + 5'h1, 32'h1);
    wr(A_BAT_BASE + 5'h2, 32'h0);
    wr(A_BAT_BASE + 5'h3, 32'h1);
    wr(5'h18, 32'hffff);
    wr(A_STAT_RES, 32'h123);
    wr(A_CTRL, 32'h1);
    cyc(12000);
    check({o_running, o_limit_signal}, 2'b11, "signal continues");
    check(o_curr_set, 16'h40, "constant current");
    check(o_reg_mode, 2'h0, "mode report");
    check({o_res_enable, o_power_set}, {1'b1, 16'hffff}, "limit set values");
    check(o_res_set, 16'h123, "resistance set value");
    rdr(A_AH);
    check(rd != 0, 1'b1, "charge counted");
    rdr(A_TIME);
    check(rd, 32'h1, "elapsed time");
    rdr(A_WH);
    check(rd != 0, 1'b1, "energy counted");
    rdr(5'h1b);
    check(rd, 32'h0, "unmapped index");
    batt <= 16'h0080;
    cyc(4);
    check(o_running, 1'b0, "threshold stop");
    rdr(A_AH);
    a1 = rd;
    cyc(300);
    rdr(A_AH);
    check(rd, a1, "counter frozen");
    wr(A_STAT_POWER, 32'h0);
    cyc(3);
    check(o_reg_mode, 2'h1, "power limiting");
    wr(A_STAT_POWER, 32'hffff);
    cyc(3);
    check(o_reg_mode, 2'h2, "resistance limiting");
    batt <= 16'h0200;
    wr(A_CTRL, 32'h1);
    cyc(300);
    check(o_running, 1'b1, "resumed");
    rdr(A_AH);
    check(rd >= a1, 1'b1, "counter kept");
    i_alarm <= 1'b1;
    cyc(2);
    check({o_running, o_input_on}, 2'b00, "alarm stop");
    i_alarm <= 1'b0;
    wr(A_CTRL, 32'h8);
    rdr(A_AH);
    check(rd, 32'h0, "exit clears");
    // dynamic test: larger current first, dynamic threshold off
    batt <= 16'h0080;
    wr(A_FUNC, 32'h4);
    wr(A_LEVEL_A, 32'h05);
    wr(A_LEVEL_B, 32'h09);
    wr(A_IVL_BASE, 32'h1);
    wr(A_IVL_BASE + 5'h1, 32'h2);
    wr(A_BAT_BASE + 5'h6, 32'h14);
    wr(A_BAT_BASE + 5'h7, 32'h8);
    wr(A_CTRL, 32'h1);
    cyc(20);
    check({o_running, o_curr_set}, {1'b1, 16'h09}, "upper first");
    cyc(100);
    check(o_curr_set, 16'h05, "lower in pause");
    cyc(400);
    check({o_running, o_input_on, o_limit_signal}, 3'b001, "capacity stop");
    report_and_stop();
  end
endmodule // swbs_sequencer_tb
